// ---- interrupt_and_timer_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_timer_unit #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire itu_pkg::core_cmd_t core_cmd,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic sp_load,
  input wire logic [7:0] sp_wdata,
  input wire logic [7:0] stack_rdata,
  output itu_pkg::stack_op_t stack_op,
  output logic [7:0] stack_pointer,
  output logic mask_flag,
  output logic busy,
  output logic entry_done,
  output logic [15:0] vector_addr,
  output logic return_done,
  output logic [15:0] return_pc,
  output logic [7:0] return_flags,
  input wire logic timer_event_pin_in,
  output logic timer_event_pin_out,
  output logic timer_event_pin_oe,
  input wire logic ext_irq_n
);
  if (ADDR_W < itu_pkg::MIN_ADDR_W) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [7:0] tdec(input logic [7:0] cnt, input logic [7:0] lat);
    tdec = (cnt == 8'h00) ? lat : cnt - 8'h01;
  endfunction

  function automatic logic [2:0] first_src(input logic [4:0] p);
    first_src = itu_pkg::SRC_EXT;
    for (int k = itu_pkg::NSRC - 1; k >= 0; k--) begin
      if (p[k]) begin
        first_src = 3'(k);
      end
    end
  endfunction

  function automatic logic [15:0] vec_of(input logic [2:0] s);
    unique case (s)
      itu_pkg::SRC_EVT: vec_of = itu_pkg::VEC_EVT;
      itu_pkg::SRC_MT: vec_of = itu_pkg::VEC_MT;
      itu_pkg::SRC_T1: vec_of = itu_pkg::VEC_T1;
      itu_pkg::SRC_T2: vec_of = itu_pkg::VEC_T2;
      default: vec_of = itu_pkg::VEC_EXT;
    endcase
  endfunction

  // ---------------------------------------------
  // APB slave
  // ---------------------------------------------
  logic [7:0] idx;
  logic hit;
  logic wr;
  logic [7:0] rd_val;
  logic [4:0] req;
  logic [4:0] en;
  logic [7:0] tmr_ctrl;
  logic [7:0] pre_latch, mt_latch, t1_latch, t2_latch;
  logic [7:0] mt_cnt, t1_cnt, t2_cnt;

  assign idx = paddr[itu_pkg::IDX_LSB +: 8];
  assign hit = (paddr[1:0] == 2'b00) && (paddr >> (itu_pkg::IDX_LSB + 8)) == '0
    && idx >= itu_pkg::IDX_PRESCALE;
  assign pready = psel & penable;
  assign pslverr = pready & ~hit;
  assign wr = pready & pwrite & hit;

  // MT, T1 and T2 latch reads show live counts so software can watch the timers
  always_comb begin
    unique case (idx)
      itu_pkg::IDX_PRESCALE: rd_val = pre_latch;
      itu_pkg::IDX_MT_LATCH: rd_val = mt_cnt;
      itu_pkg::IDX_T1_LATCH: rd_val = t1_cnt;
      itu_pkg::IDX_T2_LATCH: rd_val = t2_cnt;
      itu_pkg::IDX_INT_EN: rd_val = {3'h0, en};
      itu_pkg::IDX_INT_CTRL: rd_val = {3'h0, req};
      itu_pkg::IDX_TMR_CTRL: rd_val = tmr_ctrl;
      default: rd_val = 8'h00;
    endcase
  end

  // Read data captured in setup so it comes from a flop at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= hit ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  // Latches: zero is not a legal reload, software keeps them nonzero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_latch <= itu_pkg::LATCH_RST;
      mt_latch <= itu_pkg::LATCH_RST;
      t1_latch <= itu_pkg::LATCH_RST;
      t2_latch <= itu_pkg::LATCH_RST;
      en <= 5'h00;
      tmr_ctrl <= itu_pkg::TC_RST;
    end else if (wr) begin
      unique case (idx)
        itu_pkg::IDX_PRESCALE: pre_latch <= pwdata[7:0];
        itu_pkg::IDX_MT_LATCH: mt_latch <= pwdata[7:0];
        itu_pkg::IDX_T1_LATCH: t1_latch <= pwdata[7:0];
        itu_pkg::IDX_T2_LATCH: t2_latch <= pwdata[7:0];
        itu_pkg::IDX_INT_EN: en <= pwdata[4:0];
        itu_pkg::IDX_TMR_CTRL: tmr_ctrl <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------
  // Timers
  // ---------------------------------------------
  itu_pkg::mt_mode_t mt_mode;
  logic [8:0] pre_cnt;
  logic [3:0] div_cnt;
  logic pre_tick, div_tick, mt_tick, mt_zero;
  logic pin_q, pin_rise, pin_fall, ext_q, ext_fall;

  assign mt_mode = itu_pkg::mt_mode_t'(tmr_ctrl[itu_pkg::TC_MODE_LSB +: 2]);
  assign pre_tick = pre_cnt == ({1'b0, pre_latch} + 9'h001);
  assign div_tick = div_cnt == itu_pkg::MT_DIV_LAST;
  assign pin_rise = timer_event_pin_in & ~pin_q;
  assign pin_fall = ~timer_event_pin_in & pin_q;
  assign ext_fall = ~ext_irq_n & ext_q;
  assign mt_zero = mt_tick && mt_cnt == 8'h00;
  assign timer_event_pin_oe = mt_mode == itu_pkg::MT_PULSE;

  always_comb begin
    unique case (mt_mode)
      itu_pkg::MT_TIMER: mt_tick = div_tick;
      itu_pkg::MT_PULSE: mt_tick = div_tick;
      itu_pkg::MT_EVENT: mt_tick = pin_rise;
      itu_pkg::MT_WIDTH: mt_tick = div_tick & ~timer_event_pin_in;
    endcase
    if (tmr_ctrl[itu_pkg::TC_STOP_BIT]) begin
      mt_tick = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b1;
      ext_q <= 1'b1;
    end else begin
      pin_q <= timer_event_pin_in;
      ext_q <= ext_irq_n;
    end
  end

  // Prescaler walks 0..n+1, giving one pulse every n+2 clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 9'h000;
      div_cnt <= 4'h0;
    end else begin
      pre_cnt <= pre_tick ? 9'h000 : pre_cnt + 9'h001;
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // Reload happens on the pulse after the zero count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mt_cnt <= itu_pkg::LATCH_RST;
      t1_cnt <= itu_pkg::LATCH_RST;
      t2_cnt <= itu_pkg::LATCH_RST;
    end else begin
      if (mt_tick) begin
        mt_cnt <= tdec(mt_cnt, mt_latch);
      end
      if (pre_tick) begin
        t1_cnt <= tdec(t1_cnt, t1_latch);
        t2_cnt <= tdec(t2_cnt, t2_latch);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_event_pin_out <= 1'b0;
    end else if (mt_zero && mt_mode == itu_pkg::MT_PULSE) begin
      timer_event_pin_out <= ~timer_event_pin_out;
    end
  end

  // ---------------------------------------------
  // Requests and entry sequencer
  // ---------------------------------------------
  itu_pkg::seq_t state;
  logic [7:0] sp;
  logic reset_pend;
  logic cur_brk;
  logic [4:0] pend, set_vec, keep;
  logic take_rst, take_brk, take_irq, take_rti;
  logic [2:0] win;

  assign pend = req & en & {5{~mask_flag}};
  assign win = first_src(pend);
  assign take_rst = state == itu_pkg::ST_IDLE && core_cmd.boundary && reset_pend;
  assign take_brk = state == itu_pkg::ST_IDLE && !take_rst && core_cmd.break_instruction;
  assign take_irq = state == itu_pkg::ST_IDLE && !take_rst && !core_cmd.break_instruction
    && core_cmd.boundary && |pend;
  assign take_rti = state == itu_pkg::ST_IDLE && !take_rst && !core_cmd.break_instruction
    && !take_irq && core_cmd.return_from_irq_instruction;
  assign busy = state != itu_pkg::ST_IDLE;
  assign entry_done = state == itu_pkg::ST_VEC;
  assign stack_pointer = stack_op.addr;

  always_comb begin
    set_vec = 5'h00;
    set_vec[itu_pkg::SRC_EVT] = pin_fall;
    set_vec[itu_pkg::SRC_EXT] = ext_fall;
    set_vec[itu_pkg::SRC_MT] = mt_zero;
    set_vec[itu_pkg::SRC_T1] = pre_tick && t1_cnt == 8'h00;
    set_vec[itu_pkg::SRC_T2] = pre_tick && t2_cnt == 8'h00;
    keep = (wr && idx == itu_pkg::IDX_INT_CTRL) ? pwdata[4:0] : 5'h1F;
    if (take_irq) begin
      keep[win] = 1'b0;
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 5'h00;
    end else begin
      req <= (req & keep) | set_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= itu_pkg::ST_IDLE;
    end else begin
      unique case (state)
        itu_pkg::ST_IDLE: begin
          if (take_rst) begin
            state <= itu_pkg::ST_VEC;
          end else if (take_brk || take_irq) begin
            state <= itu_pkg::ST_PUSH_H;
          end else if (take_rti) begin
            state <= itu_pkg::ST_PULL_P;
          end
        end
        itu_pkg::ST_PUSH_H: state <= itu_pkg::ST_PUSH_L;
        itu_pkg::ST_PUSH_L: state <= itu_pkg::ST_PUSH_P;
        itu_pkg::ST_PUSH_P: state <= itu_pkg::ST_VEC;
        itu_pkg::ST_VEC: state <= itu_pkg::ST_IDLE;
        itu_pkg::ST_PULL_P: state <= itu_pkg::ST_PULL_L;
        itu_pkg::ST_PULL_L: state <= itu_pkg::ST_PULL_H;
        itu_pkg::ST_PULL_H: state <= itu_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pend <= 1'b1;
      cur_brk <= 1'b0;
      vector_addr <= 16'h0000;
    end else if (take_rst) begin
      reset_pend <= 1'b0;
      cur_brk <= 1'b0;
      vector_addr <= itu_pkg::VEC_RESET;
    end else if (take_brk) begin
      cur_brk <= 1'b1;
      vector_addr <= itu_pkg::VEC_EXT;
    end else if (take_irq) begin
      cur_brk <= 1'b0;
      vector_addr <= vec_of(win);
    end
  end

  // Stack port: pushes use SP then decrement, pulls pre-increment
  always_comb begin
    stack_op.we = state inside {itu_pkg::ST_PUSH_H, itu_pkg::ST_PUSH_L,
      itu_pkg::ST_PUSH_P};
    stack_op.re = state inside {itu_pkg::ST_PULL_P, itu_pkg::ST_PULL_L,
      itu_pkg::ST_PULL_H};
    stack_op.addr = stack_op.re ? sp + 8'h01 : sp;
    stack_op.wdata = flags_in;
    stack_op.wdata[itu_pkg::FLAG_B_BIT] = cur_brk;
    // Mask flag lives here, so the saved copy must come from here too
    stack_op.wdata[itu_pkg::FLAG_I_BIT] = mask_flag;
    if (state == itu_pkg::ST_PUSH_H) begin
      stack_op.wdata = pc_in[15:8];
    end else if (state == itu_pkg::ST_PUSH_L) begin
      stack_op.wdata = pc_in[7:0];
    end
  end


  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= itu_pkg::SP_RST;
    end else if (stack_op.we) begin
      sp <= sp - 8'h01;
    end else if (stack_op.re) begin
      sp <= sp + 8'h01;
    end else if (sp_load) begin
      sp <= sp_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_flags <= 8'h00;
      return_pc <= 16'h0000;
      return_done <= 1'b0;
    end else begin
      return_done <= state == itu_pkg::ST_PULL_H;
      unique case (state)
        itu_pkg::ST_PULL_P: return_flags <= stack_rdata;
        itu_pkg::ST_PULL_L: return_pc[7:0] <= stack_rdata;
        itu_pkg::ST_PULL_H: return_pc[15:8] <= stack_rdata;
        default: ;
      endcase
    end
  end

  // Mask starts set so no interrupt request is taken before software is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_flag <= 1'b1;
    end else if (state == itu_pkg::ST_VEC) begin
      mask_flag <= 1'b1;
    end else if (state == itu_pkg::ST_PULL_P) begin
      mask_flag <= stack_rdata[itu_pkg::FLAG_I_BIT];
    end else if (core_cmd.set_mask_instruction) begin
      mask_flag <= 1'b1;
    end else if (core_cmd.clear_mask_instruction) begin
      mask_flag <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_accept;
    take_irq |=> state == itu_pkg::ST_PUSH_H
      && (!req[$past(win)] || $past(set_vec[win]));
  endproperty
  a_accept: assert property (p_accept) else $error("accepted request not cleared");

  property p_gate;
    state == itu_pkg::ST_IDLE && !(|(req & en & {5{~mask_flag}})) && !reset_pend
      && !core_cmd.break_instruction && !core_cmd.return_from_irq_instruction |=> state == itu_pkg::ST_IDLE;
  endproperty
  a_gate: assert property (p_gate) else $error("entry without enabled request");

  property p_order;
    state == itu_pkg::ST_PUSH_H |=> state == itu_pkg::ST_PUSH_L
      ##1 state == itu_pkg::ST_PUSH_P ##1 entry_done ##1 mask_flag;
  endproperty
  a_order: assert property (p_order) else $error("push order broken");

  property p_sp_dec;
    stack_op.we |=> sp == $past(sp) - 8'h01;
  endproperty
  a_sp_dec: assert property (p_sp_dec) else $error("stack pointer not decremented");

  property p_reset_first;
    take_rst |=> entry_done && vector_addr == itu_pkg::VEC_RESET;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset vector wrong");

  property p_brk_vec;
    take_brk |=> vector_addr == itu_pkg::VEC_EXT && stack_op.we ##1 stack_op.we
      ##1 stack_op.we && stack_op.wdata[itu_pkg::FLAG_B_BIT];
  endproperty
  a_brk_vec: assert property (p_brk_vec) else $error("break entry wrong");

  property p_mt_reload;
    mt_zero |=> mt_cnt == $past(mt_latch) && req[itu_pkg::SRC_MT];
  endproperty
  a_mt_reload: assert property (p_mt_reload) else $error("mode timer reload wrong");

  property p_stop;
    tmr_ctrl[itu_pkg::TC_STOP_BIT] |=> $stable(mt_cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("mode timer ran while stopped");

  property p_pulse;
    mt_zero && mt_mode == itu_pkg::MT_PULSE |=> timer_event_pin_out != $past(timer_event_pin_out);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse output did not invert");

  property p_ext_fall;
    ext_q && !ext_irq_n |=> req[itu_pkg::SRC_EXT];
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("falling edge lost");
endmodule
`default_nettype wire

// ---- itu_pkg.sv ----
package itu_pkg;
  // ---------------------------------------------
  // Register indices (byte address = index * 4)
  // ---------------------------------------------
  localparam logic [7:0] IDX_PRESCALE = 8'hF9;
  localparam logic [7:0] IDX_MT_LATCH = 8'hFA;
  localparam logic [7:0] IDX_T1_LATCH = 8'hFB;
  localparam logic [7:0] IDX_T2_LATCH = 8'hFC;
  localparam logic [7:0] IDX_INT_EN = 8'hFD;
  localparam logic [7:0] IDX_INT_CTRL = 8'hFE;
  localparam logic [7:0] IDX_TMR_CTRL = 8'hFF;
  localparam int IDX_LSB = 2;
  localparam int MIN_ADDR_W = 10;
  // ---------------------------------------------
  // Fields, sources and reset values
  // ---------------------------------------------
  localparam int TC_MODE_LSB = 2;
  localparam int TC_STOP_BIT = 5;
  localparam int FLAG_I_BIT = 2;
  localparam int FLAG_B_BIT = 4;
  localparam int NSRC = 5;
  localparam logic [2:0] SRC_EVT = 3'h0;
  localparam logic [2:0] SRC_MT = 3'h1;
  localparam logic [2:0] SRC_T1 = 3'h2;
  localparam logic [2:0] SRC_T2 = 3'h3;
  localparam logic [2:0] SRC_EXT = 3'h4;
  localparam logic [15:0] VEC_RESET = 16'h1FFE;
  localparam logic [15:0] VEC_EVT = 16'h1FFC;
  localparam logic [15:0] VEC_MT = 16'h1FFA;
  localparam logic [15:0] VEC_T1 = 16'h1FF8;
  localparam logic [15:0] VEC_T2 = 16'h1FF6;
  localparam logic [15:0] VEC_EXT = 16'h1FF4;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] TC_RST = 8'h00;
  localparam logic [7:0] SP_RST = 8'hFF;
  localparam logic [3:0] MT_DIV_LAST = 4'hF;
  // ---------------------------------------------
  // Types
  // ---------------------------------------------
  typedef enum logic [1:0] {
    MT_TIMER = 2'b00,
    MT_PULSE = 2'b01,
    MT_EVENT = 2'b10,
    MT_WIDTH = 2'b11
  } mt_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH_H = 3'b001,
    ST_PUSH_L = 3'b010,
    ST_PUSH_P = 3'b011,
    ST_VEC = 3'b100,
    ST_PULL_P = 3'b101,
    ST_PULL_L = 3'b110,
    ST_PULL_H = 3'b111
  } seq_t;
  typedef struct packed {
    logic boundary;
    logic break_instruction;
    logic set_mask_instruction;
    logic clear_mask_instruction;
    logic return_from_irq_instruction;
  } core_cmd_t;
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } stack_op_t;
endpackage

// ---- itu_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module itu_core_model (
  input wire logic pclk,
  input wire itu_pkg::stack_op_t stack_op,
  output logic [7:0] stack_rdata,
  output itu_pkg::core_cmd_t core_cmd,
  output logic [15:0] pc_in,
  output logic [7:0] flags_in
);
  // -------------------------
  // Stack memory
  // -------------------------
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
    core_cmd = '0;
    pc_in = 16'h0000;
    flags_in = 8'h00;
  end
  always @(posedge pclk) begin
    if (stack_op.we) begin
      mem[stack_op.addr] <= stack_op.wdata;
    end
  end
  // Outside a pull the bus shows garbage, so a late sample cannot pass by luck
  assign stack_rdata = stack_op.re ? mem[stack_op.addr] : ~mem[stack_op.addr];
  // -------------------------
  // Command pulses, context held until the next command
  // -------------------------
  task automatic issue(input itu_pkg::core_cmd_t c, input logic [15:0] pc, input logic [7:0] fl);
    @(posedge pclk);
    core_cmd <= c;
    pc_in <= pc;
    flags_in <= fl;
    @(posedge pclk);
    core_cmd <= '0;
  endtask
endmodule
`default_nettype wire

// ---- interrupt_and_timer_unit_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module interrupt_and_timer_unit_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sp_load;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, c1;
  itu_pkg::core_cmd_t core_cmd;
  itu_pkg::stack_op_t stack_op;
  logic [15:0] pc_in, vector_addr, return_pc, v, pc;
  logic [7:0] flags_in, sp_wdata, stack_rdata, stack_pointer, return_flags, sp0, fl, lat, pre;
  logic mask_flag, busy, entry_done, return_done, evt_in, evt_out, evt_oe, evt_drv, ext_irq_n;
  logic e, o, bz;
  int n_mismatch, samples_checked, cycles, cyc, k, per, t;
  assign evt_in = evt_oe ? evt_out : evt_drv;
  interrupt_and_timer_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_cmd(core_cmd), .pc_in(pc_in),
    .flags_in(flags_in), .sp_load(sp_load), .sp_wdata(sp_wdata), .stack_rdata(stack_rdata),
    .stack_op(stack_op), .stack_pointer(stack_pointer), .mask_flag(mask_flag), .busy(busy),
    .entry_done(entry_done), .vector_addr(vector_addr), .return_done(return_done),
    .return_pc(return_pc), .return_flags(return_flags), .timer_event_pin_in(evt_in),
    .timer_event_pin_out(evt_out), .timer_event_pin_oe(evt_oe), .ext_irq_n(ext_irq_n));
  itu_core_model u_core (.pclk(pclk), .stack_op(stack_op), .stack_rdata(stack_rdata),
    .core_cmd(core_cmd), .pc_in(pc_in), .flags_in(flags_in));
  // -------------------------
  // Clock, watchdog, verdict
  // -------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // -------------------------
  // APB master
  // -------------------------
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(d, exp);
  endtask
  task automatic poll(input int b);
    cyc = 0;
    do begin
      apb(1'b0, itu_pkg::IDX_INT_CTRL, 8'h00);
      cyc += 3;
    end while (d[b] !== 1'b1 && cyc < 6000);
  endtask
  task automatic take();
    v = 16'h0000;
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      if (i == 0) bz = busy;
      if (entry_done === 1'b1) v = vector_addr;
    end
  endtask
  task automatic enter(input logic [4:0] c, input logic [15:0] exp);
    u_core.issue(c, pc, fl);
    take();
    check(v, exp);
    check(bz, exp != 16'h0000);
  endtask
  task automatic ret();
    u_core.issue(5'h01, pc, fl);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (return_done !== 1'b1 && k < 10);
    check(return_pc, pc);
    check(stack_pointer, sp0);
  endtask
  task automatic edge_wait();
    o = evt_out;
    k = 0;
    while (evt_out === o && k < 16 * (lat + 3)) begin
      @(posedge pclk);
      k++;
    end
  endtask
  // -------------------------
  // Main sequence
  // -------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    sp_load = 1'b0;
    sp_wdata = 8'h00;
    evt_drv = 1'b1;
    ext_irq_n = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    k = $urandom(63351);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check(mask_flag, 1);
    rdchk(itu_pkg::IDX_PRESCALE, 32'hFF);
    rdchk(itu_pkg::IDX_TMR_CTRL, 32'h00);
    apb(1'b0, 8'h00, 8'h00);
    check({e, d[30:0]}, 32'h80000000);
    u_core.issue(5'h10, 16'h0000, 8'h00);
    take();
    check(v, itu_pkg::VEC_RESET);
    apb(1'b1, itu_pkg::IDX_TMR_CTRL, 8'h20);
    apb(1'b0, itu_pkg::IDX_MT_LATCH, 8'h00);
    c1 = d;
    repeat (64) @(posedge pclk);
    rdchk(itu_pkg::IDX_MT_LATCH, c1);
    apb(1'b1, itu_pkg::IDX_INT_CTRL, 8'h00);
    apb(1'b1, itu_pkg::IDX_INT_CTRL, 8'h1F);
    rdchk(itu_pkg::IDX_INT_CTRL, 32'h00);
    lat = 8'($urandom_range(0, 31));
    apb(1'b1, itu_pkg::IDX_INT_EN, lat);
    rdchk(itu_pkg::IDX_INT_EN, lat);
    pre = 8'($urandom_range(1, 3));
    apb(1'b1, itu_pkg::IDX_PRESCALE, pre);
    apb(1'b1, itu_pkg::IDX_TMR_CTRL, 8'h00);
    for (int s = 2; s >= 0; s--) begin
      per = (s == 0) ? 16 : pre + 2;
      lat = 8'($urandom_range(20, 40));
      apb(1'b1, itu_pkg::IDX_MT_LATCH + 8'(s), lat);
      t = per * (lat + 1);
      poll(s + 1);
      apb(1'b1, itu_pkg::IDX_INT_CTRL, 8'h00);
      poll(s + 1);
      check(cyc >= t - 9 && cyc <= t + 6, 1);
    end
    apb(1'b1, itu_pkg::IDX_TMR_CTRL, 8'h08);
    apb(1'b1, itu_pkg::IDX_INT_CTRL, 8'h00);
    repeat (lat + 2) begin
      @(posedge pclk);
      evt_drv <= 1'b0;
      repeat (4) @(posedge pclk);
      evt_drv <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    apb(1'b0, itu_pkg::IDX_INT_CTRL, 8'h00);
    check(d & 32'h3, 32'h3);
    apb(1'b1, itu_pkg::IDX_TMR_CTRL, 8'h04);
    @(posedge pclk);
    check(evt_oe, 1);
    edge_wait();
    edge_wait();
    check(k >= 16 * (lat + 1) - 1 && k <= 16 * (lat + 1) + 1, 1);
    apb(1'b1, itu_pkg::IDX_TMR_CTRL, 8'h0C);
    apb(1'b0, itu_pkg::IDX_MT_LATCH, 8'h00);
    c1 = d;
    repeat (100) @(posedge pclk);
    rdchk(itu_pkg::IDX_MT_LATCH, c1);
    evt_drv <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, itu_pkg::IDX_MT_LATCH, 8'h00);
    check(d == c1, 0);
    evt_drv <= 1'b1;
    // -------------------------
    // Entry, return, masking
    // -------------------------
    apb(1'b1, itu_pkg::IDX_TMR_CTRL, 8'h20);
    apb(1'b1, itu_pkg::IDX_INT_EN, 8'h11);
    apb(1'b1, itu_pkg::IDX_INT_CTRL, 8'h00);
    ext_irq_n <= 1'b0;
    evt_drv <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_irq_n <= 1'b1;
    evt_drv <= 1'b1;
    apb(1'b0, itu_pkg::IDX_INT_CTRL, 8'h00);
    check(d & 32'h11, 32'h11);
    pc = 16'($urandom());
    fl = 8'($urandom()) & 8'hEB;
    enter(5'h10, 16'h0000);
    u_core.issue(5'h02, pc, fl);
    @(posedge pclk);
    check(mask_flag, 0);
    sp0 = 8'($urandom_range(64, 240));
    sp_load <= 1'b1;
    sp_wdata <= sp0;
    @(posedge pclk);
    sp_load <= 1'b0;
    enter(5'h10, itu_pkg::VEC_EVT);
    check(mask_flag, 1);
    check(u_core.mem[sp0], pc[15:8]);
    check(u_core.mem[sp0 - 8'h01], pc[7:0]);
    check(u_core.mem[sp0 - 8'h02], fl);
    check(stack_pointer, sp0 - 8'h03);
    apb(1'b0, itu_pkg::IDX_INT_CTRL, 8'h00);
    check(d & 32'h11, 32'h10);
    ret();
    check(return_flags, fl);
    check(mask_flag, 0);
    enter(5'h10, itu_pkg::VEC_EXT);
    ret();
    enter(5'h08, itu_pkg::VEC_EXT);
    check(u_core.mem[sp0 - 8'h02], fl | 8'h10);
    ret();
    u_core.issue(5'h04, pc, fl);
    @(posedge pclk);
    check(mask_flag, 1);
    conclude();
  end
endmodule
`default_nettype wire
